// File: hdl/sbp_mem_end.sv
`timescale 1ns/1ns
`include "sbp_params.svh"
module sbp_mem_end (
  // System clock and reset.
  input  wire logic  CLK_SYS_IN,
  input  wire logic  RESET_N_IN,
  // Link to the controller.
  sbp_link_if.mem    SBP_LINK,
  // Activity strobes for the user side.
  output logic       RD_START_OUT,
  output logic       WR_START_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  sbp_pkg::link_in_type link_raw;                  // Pins as they arrive.
  sbp_pkg::link_in_type s1_q, s1_d;                // First sync stage.
  sbp_pkg::link_in_type s2_q, s2_d;                // Second sync stage.
  logic                 k_prev_q, k_prev_d;        // Last synced K level.
  logic                 kn_prev_q, kn_prev_d;      // Last synced K_N level.
  logic                 k_rise;                    // K rise seen this cycle.
  logic                 kn_rise;                   // K_N rise seen this cycle.
  logic                 edge_ev;                   // Either rise.
  logic                 rd_req;                    // Read request allowed.
  logic                 wr_req;                    // Write request allowed.
  logic                 rd_go;                     // Read starts now.
  logic                 wr_go;                     // Write starts now.
  logic                 prev_rd_q, prev_rd_d;      // Read began at last K rise.
  logic                 prev_wr_q, prev_wr_d;      // Write began at last K rise.
  logic [`SBP_RD_DEPTH-1:0] rd_v_q, rd_v_d;        // Read start history.
  sbp_pkg::base_type    rd_a_q [`SBP_RD_DEPTH];    // Read base per history slot.
  sbp_pkg::base_type    rd_a_d [`SBP_RD_DEPTH];
  logic [`SBP_WR_DEPTH-1:0] wr_v_q, wr_v_d;        // Write start history.
  sbp_pkg::base_type    wr_a_q [`SBP_WR_DEPTH];    // Write base per history slot.
  sbp_pkg::base_type    wr_a_d [`SBP_WR_DEPTH];
  sbp_pkg::word_type    mem_q [`SBP_WORDS];        // Storage array.
  sbp_pkg::word_type    mem_d [`SBP_WORDS];
  logic                 wr_hit;                    // A write word lands now.
  sbp_pkg::waddr_type   wr_addr;                   // Where it lands.
  logic                 rd_hit;                    // A read word leaves now.
  sbp_pkg::waddr_type   rd_addr;                   // Where it comes from.
  sbp_pkg::word_type    merged;                    // Old word with lanes replaced.
  sbp_pkg::word_type    q_q, q_d;                  // Read data register.
  logic                 oe_q, oe_d;                // Read output enable.
  logic                 rd_st_q, rd_st_d;          // Read start strobe.
  logic                 wr_st_q, wr_st_d;          // Write start strobe.

  ////////////////////////////////////////////////////////////////////////////
  // Input synchroniser.

  // Every pin, the two clocks included, passes two flops. All fields share
  // the same delay, so data and clock stay aligned after the crossing.
  always_comb begin
    link_raw.k      = SBP_LINK.k;
    link_raw.k_n    = SBP_LINK.k_n;
    link_raw.rps_n  = SBP_LINK.read_port_select_n;
    link_raw.wps_n  = SBP_LINK.write_port_select_n;
    link_raw.addr   = SBP_LINK.addr;
    link_raw.d      = SBP_LINK.d;
    link_raw.mask_n = SBP_LINK.byte_lane_mask_n;
    s1_d            = link_raw;
    s2_d            = s1_q;
    k_prev_d        = s2_q.k;
    kn_prev_d       = s2_q.k_n;
  end

  // Selects reset high so the first cycles look deselected.
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      s1_q      <= '{k: 1'b1, k_n: 1'b1, rps_n: 1'b1, wps_n: 1'b1, default: '1};
      s2_q      <= '{k: 1'b1, k_n: 1'b1, rps_n: 1'b1, wps_n: 1'b1, default: '1};
      k_prev_q  <= 1'b1;
      kn_prev_q <= 1'b1;
    end else begin
      s1_q      <= s1_d;
      s2_q      <= s2_d;
      k_prev_q  <= k_prev_d;
      kn_prev_q <= kn_prev_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection and burst pointers.

  // Only the second sync stage and its delayed copy are compared. With no
  // edges nothing below moves, so a stopped clock freezes all state.
  always_comb begin
    k_rise  = s2_q.k & ~k_prev_q;
    kn_rise = s2_q.k_n & ~kn_prev_q;
    edge_ev = k_rise | kn_rise;
    wr_hit  = 1'b0;
    wr_addr = '0;
    rd_hit  = 1'b0;
    rd_addr = '0;
    // Slot n-1 now becomes slot n; writes are at least four edges apart,
    // so at most one word lands per edge.
    for (int w = 0; w < `SBP_BURST; w++) begin
      if (edge_ev && wr_v_q[`SBP_WR_FIRST+w-1]) begin
        wr_hit  = 1'b1;
        wr_addr = {wr_a_q[`SBP_WR_FIRST+w-1], sbp_pkg::widx_type'(w)};
      end
      if (edge_ev && rd_v_q[`SBP_RD_FIRST+w-1]) begin
        rd_hit  = 1'b1;
        rd_addr = {rd_a_q[`SBP_RD_FIRST+w-1], sbp_pkg::widx_type'(w)};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lane merge.

  // Each lane takes the new data when its mask is low and keeps the stored
  // byte otherwise; the mask is the one sampled with this very word.
  // Lane count 2 gives the 18-bit form, lane count 4 the 36-bit form.
  for (genvar l = 0; l < `SBP_LANES; l++) begin : g_lane
    assign merged[l*`SBP_LANE_W +: `SBP_LANE_W] = s2_q.mask_n[l] ?
      mem_q[wr_addr][l*`SBP_LANE_W +: `SBP_LANE_W] :
      s2_q.d[l*`SBP_LANE_W +: `SBP_LANE_W];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode, history and storage.

  // A select that started an operation at the previous K rise is ignored,
  // which drops a second request of the same type.
  always_comb begin
    rd_req    = ~s2_q.rps_n & ~prev_rd_q;
    wr_req    = ~s2_q.wps_n & ~prev_wr_q;
    // Reads win unless a read just started, which lets a write through.
    rd_go     = k_rise & rd_req;
    wr_go     = k_rise & wr_req & ~rd_req;
    prev_rd_d = prev_rd_q;
    prev_wr_d = prev_wr_q;
    rd_v_d    = rd_v_q;
    wr_v_d    = wr_v_q;
    rd_a_d    = rd_a_q;
    wr_a_d    = wr_a_q;
    mem_d     = mem_q;
    q_d       = q_q;
    oe_d      = oe_q;
    rd_st_d   = rd_go;
    wr_st_d   = wr_go;
    if (edge_ev) begin
      // The histories age by one edge; slot 0 holds this edge's start.
      for (int i = `SBP_RD_DEPTH-1; i > 0; i--) begin
        rd_v_d[i] = rd_v_q[i-1];
        rd_a_d[i] = rd_a_q[i-1];
      end
      for (int i = `SBP_WR_DEPTH-1; i > 0; i--) begin
        wr_v_d[i] = wr_v_q[i-1];
        wr_a_d[i] = wr_a_q[i-1];
      end
      rd_v_d[0] = rd_go;
      rd_a_d[0] = s2_q.addr;
      wr_v_d[0] = wr_go;
      wr_a_d[0] = s2_q.addr;
      // Starts are only decided on K; K_N leaves prev_rd_q and prev_wr_q untouched.
      if (k_rise) begin
        prev_rd_d = rd_go;
        prev_wr_d = wr_go;
      end
      // Write data is ignored unless a write burst owns this edge.
      if (wr_hit) begin
        mem_d[wr_addr] = merged;
      end
      // The bus is released at a K_N rise that carries no read word.
      if (kn_rise) begin
        oe_d = 1'b0;
      end
      // Reads see the array before this edge's write; a write started one
      // cycle earlier is fully stored by the time the first word leaves.
      if (rd_hit) begin
        q_d  = mem_q[rd_addr];
        oe_d = 1'b1;
      end
    end
  end

  // Every flop, the storage array included, resets to a constant, so a read
  // of an unwritten word is known. The price is a larger reset tree.
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      prev_rd_q <= 1'b0;
      prev_wr_q <= 1'b0;
      rd_v_q    <= '0;
      wr_v_q    <= '0;
      for (int i = 0; i < `SBP_RD_DEPTH; i++) begin
        rd_a_q[i] <= '0;
      end
      for (int i = 0; i < `SBP_WR_DEPTH; i++) begin
        wr_a_q[i] <= '0;
      end
      for (int i = 0; i < `SBP_WORDS; i++) begin
        mem_q[i] <= '0;
      end
      q_q       <= '0;
      oe_q      <= 1'b0;
      rd_st_q   <= 1'b0;
      wr_st_q   <= 1'b0;
    end else begin
      prev_rd_q <= prev_rd_d;
      prev_wr_q <= prev_wr_d;
      rd_v_q    <= rd_v_d;
      wr_v_q    <= wr_v_d;
      rd_a_q    <= rd_a_d;
      wr_a_q    <= wr_a_d;
      mem_q     <= mem_d;
      q_q       <= q_d;
      oe_q      <= oe_d;
      rd_st_q   <= rd_st_d;
      wr_st_q   <= wr_st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // All outputs come straight from flops.
  assign SBP_LINK.q    = q_q;
  assign SBP_LINK.q_oe = oe_q;
  assign RD_START_OUT  = rd_st_q;
  assign WR_START_OUT  = wr_st_q;

endmodule

// File: hdl/sbp_params.svh
`ifndef SBP_PARAMS_SVH
`define SBP_PARAMS_SVH
// Organisation: lane count 4 gives 36-bit words, 2 gives 18-bit words.
`define SBP_LANES 4
`define SBP_LANE_W 9
`define SBP_WORD_W (`SBP_LANES * `SBP_LANE_W)
// Burst base address width, burst length and word index width.
`define SBP_BASE_W 4
`define SBP_BURST 4
`define SBP_WIDX_W 2
`define SBP_WORDS ((1 << `SBP_BASE_W) * `SBP_BURST)
// Edge offsets after the starting K rise.
`define SBP_WR_FIRST 2
`define SBP_RD_FIRST 5
`define SBP_WR_DEPTH 6
`define SBP_RD_DEPTH 9
`define SBP_H_RD_CAP 6
`define SBP_H_RD_DEPTH 10
`define SBP_H_WR_PREP 1
`define SBP_H_WR_DEPTH 5
// Link clock made by the controller from the system clock.
`define SBP_SYS_PERIOD_NS 40
`define SBP_K_PERIOD_NS 320
`define SBP_K_PHASES (`SBP_K_PERIOD_NS / `SBP_SYS_PERIOD_NS)
`define SBP_K_HALF (`SBP_K_PHASES / 2)
`define SBP_PH_PREP_K 3'h7
`define SBP_PH_PREP_KN 3'h3
`define SBP_PH_TAKE 3'h6
`define SBP_PH_CAP_A 3'h6
`define SBP_PH_CAP_B 3'h2
`define SBP_PH_K 3'h0
`define SBP_PH_KN 3'h4
`endif

// File: hdl/sbp_pkg.sv
`include "sbp_params.svh"
package sbp_pkg;
  typedef logic [`SBP_WORD_W-1:0]  word_type;
  typedef logic [`SBP_LANES-1:0]   mask_type;
  typedef logic [`SBP_BASE_W-1:0]  base_type;
  typedef logic [`SBP_WIDX_W-1:0]  widx_type;
  typedef logic [`SBP_BASE_W+`SBP_WIDX_W-1:0] waddr_type;
  typedef logic [2:0]              phase_type;
  typedef logic [`SBP_BURST-1:0][`SBP_WORD_W-1:0] burst_data_type;
  typedef logic [`SBP_BURST-1:0][`SBP_LANES-1:0]  burst_mask_type;
  // Link pins as the memory end samples them.
  typedef struct packed {
    logic     k;
    logic     k_n;
    logic     rps_n;
    logic     wps_n;
    base_type addr;
    word_type d;
    mask_type mask_n;
  } link_in_type;
endpackage

// File: hdl/sbp_link_if.sv
`timescale 1ns/1ns
`include "sbp_params.svh"
interface sbp_link_if;
  logic              k;                    // Positive input clock.
  logic              k_n;                  // Negative input clock.
  logic              read_port_select_n;   // Read port select, active low.
  logic              write_port_select_n;  // Write port select, active low.
  sbp_pkg::base_type addr;                 // Shared burst base address.
  sbp_pkg::word_type d;                    // Write data.
  sbp_pkg::mask_type byte_lane_mask_n;     // Lane write masks, active low.
  sbp_pkg::word_type q;                    // Read data from the memory end.
  logic              q_oe;                 // Read data output enable.
  sbp_pkg::word_type q_bus;                // Resolved read data wire.

  // A released read bus shows the inverse of the last word. A capture taken
  // outside the driven window then cannot pass for good data.
  assign q_bus = q_oe ? q : ~q;

  modport ctrl (output k, k_n, read_port_select_n, write_port_select_n,
                output addr, d, byte_lane_mask_n, input q_bus);
  modport mem  (input k, k_n, read_port_select_n, write_port_select_n,
                input addr, d, byte_lane_mask_n, output q, q_oe);
endinterface

// File: hdl/sbp_ctrl_end.sv
`timescale 1ns/1ns
`include "sbp_params.svh"
module sbp_ctrl_end (
  // System clock and reset.
  input  wire logic                    CLK_SYS_IN,
  input  wire logic                    RESET_N_IN,
  // Link to the memory end.
  sbp_link_if.ctrl                     SBP_LINK,
  // Command port.
  input  wire logic                    CMD_VALID_IN,
  input  wire logic                    CMD_WRITE_IN,
  input  wire sbp_pkg::base_type       CMD_ADDR_IN,
  input  wire sbp_pkg::burst_data_type CMD_WDATA_IN,
  input  wire sbp_pkg::burst_mask_type CMD_MASK_N_IN,
  output logic                         CMD_RD_READY_OUT,
  output logic                         CMD_WR_READY_OUT,
  // Read result.
  output logic                         RD_VALID_OUT,
  output sbp_pkg::burst_data_type      RD_DATA_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  sbp_pkg::phase_type       ph_q, ph_d;            // Link clock phase.
  logic                     k_q, k_d;              // K pin.
  logic                     kn_q, kn_d;            // K_N pin.
  logic                     take;                  // Command taken now.
  logic                     go_rd_q, go_rd_d;      // Read starts at next K.
  logic                     go_wr_q, go_wr_d;      // Write starts at next K.
  logic [`SBP_H_RD_DEPTH-1:0] rd_v_q, rd_v_d;      // Read start history.
  logic [`SBP_H_WR_DEPTH-1:0] wr_v_q, wr_v_d;      // Write start history.
  sbp_pkg::base_type        addr_q, addr_d;        // Address pins.
  logic                     rps_q, rps_d;          // Read select pin.
  logic                     wps_q, wps_d;          // Write select pin.
  sbp_pkg::word_type        d_q, d_d;              // Write data pins.
  sbp_pkg::mask_type        m_q, m_d;              // Mask pins.
  sbp_pkg::burst_data_type  wbuf_q, wbuf_d;        // Write burst buffer.
  sbp_pkg::burst_mask_type  mbuf_q, mbuf_d;        // Mask burst buffer.
  sbp_pkg::word_type        q_s1_q, q_s2_q;        // Read data sync.
  sbp_pkg::burst_data_type  asm_q, asm_d;          // Read burst assembly.
  sbp_pkg::burst_data_type  rdat_q, rdat_d;        // Completed read burst.
  logic                     rval_q, rval_d;        // Completed strobe.
  logic                     rrdy_q, rrdy_d;        // Read may be offered.
  logic                     wrdy_q, wrdy_d;        // Write may be offered.

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer.

  // K is the system clock divided by the phase count; pins change one
  // system cycle before each link edge so the far sync sees them stable.
  always_comb begin
    ph_d    = (ph_q == sbp_pkg::phase_type'(`SBP_K_PHASES-1)) ? '0 : ph_q + 3'h1;
    k_d     = (ph_d < sbp_pkg::phase_type'(`SBP_K_HALF));
    kn_d    = ~k_d;
    take    = CMD_VALID_IN & (CMD_WRITE_IN ? wrdy_q : rrdy_q);
    go_rd_d = go_rd_q | (take & ~CMD_WRITE_IN);
    go_wr_d = go_wr_q | (take & CMD_WRITE_IN);
    rd_v_d  = rd_v_q;
    wr_v_d  = wr_v_q;
    addr_d  = take ? CMD_ADDR_IN : addr_q;
    rps_d   = rps_q;
    wps_d   = wps_q;
    d_d     = d_q;
    m_d     = m_q;
    wbuf_d  = (take & CMD_WRITE_IN) ? CMD_WDATA_IN : wbuf_q;
    mbuf_d  = (take & CMD_WRITE_IN) ? CMD_MASK_N_IN : mbuf_q;
    asm_d   = asm_q;
    rdat_d  = rdat_q;
    rval_d  = 1'b0;
    // One start per K cycle, never a repeat of the last type. A write also
    // waits for the previous burst to leave the single buffer.
    rrdy_d  = (ph_d == `SBP_PH_TAKE) & ~rd_v_q[1];
    wrdy_d  = (ph_d == `SBP_PH_TAKE) & ~wr_v_q[1] & ~wr_v_q[3];
    if ((ph_d == `SBP_PH_K) || (ph_d == `SBP_PH_KN)) begin
      rd_v_d = {rd_v_q[`SBP_H_RD_DEPTH-2:0], go_rd_q & (ph_d == `SBP_PH_K)};
      wr_v_d = {wr_v_q[`SBP_H_WR_DEPTH-2:0], go_wr_q & (ph_d == `SBP_PH_K)};
      if (ph_d == `SBP_PH_K) begin
        go_rd_d = 1'b0;
        go_wr_d = 1'b0;
      end
    end
    // Selects low for the coming K rise only; both high means idle. The
    // command is taken in the cycle just before this phase, so the next
    // values are used; the registered flags would still be low here.
    if (ph_d == `SBP_PH_PREP_K) begin
      rps_d = ~go_rd_d;
      wps_d = ~go_wr_d;
    end else if (ph_d == `SBP_PH_PREP_KN) begin
      rps_d = 1'b1;
      wps_d = 1'b1;
    end
    // Word w goes out at the edge where its burst reaches slot 2+w.
    if ((ph_d == `SBP_PH_PREP_K) || (ph_d == `SBP_PH_PREP_KN)) begin
      d_d = '0;
      m_d = '1;
      for (int w = 0; w < `SBP_BURST; w++) begin
        if (wr_v_q[`SBP_H_WR_PREP+w]) begin
          d_d = wbuf_q[w];
          m_d = mbuf_q[w];
        end
      end
    end
    // Read words are caught six cycles after their edge.
    if ((ph_d == `SBP_PH_CAP_A) || (ph_d == `SBP_PH_CAP_B)) begin
      for (int w = 0; w < `SBP_BURST; w++) begin
        if (rd_v_q[`SBP_H_RD_CAP+w]) begin
          asm_d[w] = q_s2_q;
        end
      end
      if (rd_v_q[`SBP_H_RD_DEPTH-1]) begin
        rdat_d = asm_d;
        rval_d = 1'b1;
      end
    end
  end

  // Both clocks park high in reset, which gives the quickest restart.
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      ph_q    <= '0;
      k_q     <= 1'b1;
      kn_q    <= 1'b1;
      go_rd_q <= 1'b0;
      go_wr_q <= 1'b0;
      rd_v_q  <= '0;
      wr_v_q  <= '0;
      addr_q  <= '0;
      rps_q   <= 1'b1;
      wps_q   <= 1'b1;
      d_q     <= '0;
      m_q     <= '1;
      wbuf_q  <= '0;
      mbuf_q  <= '1;
      q_s1_q  <= '0;
      q_s2_q  <= '0;
      asm_q   <= '0;
      rdat_q  <= '0;
      rval_q  <= 1'b0;
      rrdy_q  <= 1'b0;
      wrdy_q  <= 1'b0;
    end else begin
      ph_q    <= ph_d;
      k_q     <= k_d;
      kn_q    <= kn_d;
      go_rd_q <= go_rd_d;
      go_wr_q <= go_wr_d;
      rd_v_q  <= rd_v_d;
      wr_v_q  <= wr_v_d;
      addr_q  <= addr_d;
      rps_q   <= rps_d;
      wps_q   <= wps_d;
      d_q     <= d_d;
      m_q     <= m_d;
      wbuf_q  <= wbuf_d;
      mbuf_q  <= mbuf_d;
      q_s1_q  <= SBP_LINK.q_bus;
      q_s2_q  <= q_s1_q;
      asm_q   <= asm_d;
      rdat_q  <= rdat_d;
      rval_q  <= rval_d;
      rrdy_q  <= rrdy_d;
      wrdy_q  <= wrdy_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign SBP_LINK.k                   = k_q;
  assign SBP_LINK.k_n                 = kn_q;
  assign SBP_LINK.read_port_select_n  = rps_q;
  assign SBP_LINK.write_port_select_n = wps_q;
  assign SBP_LINK.addr                = addr_q;
  assign SBP_LINK.d                   = d_q;
  assign SBP_LINK.byte_lane_mask_n    = m_q;
  assign CMD_RD_READY_OUT             = rrdy_q;
  assign CMD_WR_READY_OUT             = wrdy_q;
  assign RD_VALID_OUT                 = rval_q;
  assign RD_DATA_OUT                  = rdat_q;

endmodule

// File: dv/sbp_link_checker.sv
`timescale 1ns/1ns
module sbp_link_checker (
  // Clock and reset of both ends.
  input wire logic              CLK_SYS_IN,
  input wire logic              RESET_N_IN,
  // Link signals, watched only.
  input wire logic              k,
  input wire logic              k_n,
  input wire logic              read_port_select_n,
  input wire logic              write_port_select_n,
  input wire sbp_pkg::base_type addr,
  input wire sbp_pkg::word_type d,
  input wire sbp_pkg::mask_type byte_lane_mask_n,
  input wire logic              q_oe
);
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RESET_N_IN);
  logic       k_q, k_d, rsel_q, rsel_d, wsel_q, wsel_d; // Selects seen at the last K rise.
  logic [5:0] age_q, age_d;                            // Cycles since the last read start.
  wire        k_rise = k && !k_q;
  // The age saturates so that a long idle spell cannot wrap into a false match.
  always_comb begin
    k_d = k;
    rsel_d = k_rise ? read_port_select_n : rsel_q;
    wsel_d = k_rise ? write_port_select_n : wsel_q;
    age_d = (k_rise && !read_port_select_n) ? 6'h00 : age_q + {5'h00, age_q != 6'h3f};
  end
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      k_q <= 1'b1;
      rsel_q <= 1'b1;
      wsel_q <= 1'b1;
      age_q <= 6'h3f;
    end else begin
      k_q <= k_d;
      rsel_q <= rsel_d;
      wsel_q <= wsel_d;
      age_q <= age_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////////////
  link_clk_shape_a : assert property ($rose(k) |-> k [*4] ##1 !k [*4] ##1 k)
    else $error("Link clock period or duty is wrong.");
  clk_pair_a : assert property ($rose(k) |-> !k_n)
    else $error("Link clocks are not complementary.");
  sel_hold_a : assert property ($rose(k) |-> ##1 $stable(read_port_select_n)
    && $stable(write_port_select_n) && $stable(addr)) else $error("Command moved at K rise.");
  rd_spacing_a : assert property (k_rise && !read_port_select_n |-> rsel_q)
    else $error("Two reads on consecutive K rises.");
  wr_spacing_a : assert property (k_rise && !write_port_select_n |-> wsel_q)
    else $error("Two writes on consecutive K rises.");
  data_setup_a : assert property ($changed(d) |=> $rose(k) || $rose(k_n))
    else $error("Write data changed away from a clock rise.");
  mask_setup_a : assert property ($changed(byte_lane_mask_n) |=> $rose(k) || $rose(k_n))
    else $error("Lane masks changed away from a clock rise.");
  rd_latency_a : assert property ($rose(q_oe) |-> age_q >= 6'h14 && age_q <= 6'h18)
    else $error("Read data appeared at the wrong latency.");
  rd_release_a : assert property ($rose(q_oe) |-> q_oe [*8] ##1 q_oe [*8] ##1 !q_oe)
    else $error("Read bus not released after the burst.");
endmodule

// File: dv/sram_burst_port_protocol_tb.sv
`timescale 1ns/1ns
module sram_burst_port_protocol_tb;
  logic                    clk_sys, rst_n, cmd_valid, cmd_write, rd_ready, wr_ready;
  logic                    rd_valid, rd_start2, wr_start2;
  sbp_pkg::base_type       cmd_addr;
  sbp_pkg::burst_data_type cmd_wdata, rd_data;
  sbp_pkg::burst_mask_type cmd_mask;
  sbp_pkg::word_type       mem_m [64]; // Expected array contents.
  int                      n_fail, compares;
  int                      rd_cnt = 0, wr_cnt = 0; // Starts seen on the second link.
  sbp_link_if link ();
  sbp_link_if link2 (); // Second link, driven by the bench to break the spacing on purpose.
  sbp_ctrl_end i_sbp_ctrl_end (.CLK_SYS_IN(clk_sys), .RESET_N_IN(rst_n), .SBP_LINK(link),
    .CMD_VALID_IN(cmd_valid), .CMD_WRITE_IN(cmd_write), .CMD_ADDR_IN(cmd_addr),
    .CMD_WDATA_IN(cmd_wdata), .CMD_MASK_N_IN(cmd_mask), .CMD_RD_READY_OUT(rd_ready),
    .CMD_WR_READY_OUT(wr_ready), .RD_VALID_OUT(rd_valid), .RD_DATA_OUT(rd_data));
  sbp_mem_end i_sbp_mem_end (.CLK_SYS_IN(clk_sys), .RESET_N_IN(rst_n), .SBP_LINK(link),
    .RD_START_OUT(), .WR_START_OUT());
  sbp_mem_end i_sbp_mem_end_2 (.CLK_SYS_IN(clk_sys), .RESET_N_IN(rst_n), .SBP_LINK(link2),
    .RD_START_OUT(rd_start2), .WR_START_OUT(wr_start2));
  sbp_link_checker i_sbp_link_checker (.CLK_SYS_IN(clk_sys), .RESET_N_IN(rst_n), .k(link.k),
    .k_n(link.k_n), .read_port_select_n(link.read_port_select_n), .addr(link.addr),
    .write_port_select_n(link.write_port_select_n), .d(link.d), .q_oe(link.q_oe),
    .byte_lane_mask_n(link.byte_lane_mask_n));
  ////////////////////////////////////////////////////////////////////////////////////////
  // Counts operations that the second memory end really starts.
  always @(posedge clk_sys) begin
    if (rd_start2 === 1'b1) rd_cnt <= rd_cnt + 1;
    if (wr_start2 === 1'b1) wr_cnt <= wr_cnt + 1;
  end
  task automatic cmp_val(input sbp_pkg::word_type got, input sbp_pkg::word_type exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Offers a command and holds it until the controller takes it; a stuck port is a fault.
  task automatic issue(input logic wr, input sbp_pkg::base_type a,
                       input sbp_pkg::burst_data_type wd, input sbp_pkg::burst_mask_type m);
    int i;
    // One idle falling edge first, so valid is never lowered and raised in one step.
    @(negedge clk_sys);
    cmd_write = wr;
    cmd_addr = a;
    cmd_wdata = wd;
    cmd_mask = m;
    cmd_valid = 1'b1;
    for (i = 0; i < 40 && (wr ? wr_ready : rd_ready) !== 1'b1; i++) @(negedge clk_sys);
    if (i == 40) begin
      n_fail++;
      $display("ERROR at %0t ns: got %h expected %h", $time, 1'b0, 1'b1);
    end
    @(negedge clk_sys);
    cmd_valid = 1'b0;
  endtask
  // Writes a burst and merges the enabled lanes into the expected array.
  task automatic wr_burst(input sbp_pkg::base_type a, input sbp_pkg::burst_data_type wd,
                          input sbp_pkg::burst_mask_type m);
    issue(1'b1, a, wd, m);
    for (int w = 0; w < 4; w++)
      for (int l = 0; l < 4; l++)
        if (!m[w][l]) mem_m[{a, w[1:0]}][9*l +: 9] = wd[w][9*l +: 9];
  endtask
  task automatic rd_burst(input sbp_pkg::base_type a);
    int i;
    issue(1'b0, a, '0, '1);
    for (i = 0; i < 80 && rd_valid !== 1'b1; i++) @(negedge clk_sys);
    cmp_val({35'h0, rd_valid}, 36'h1);
    for (i = 0; i < 4; i++) cmp_val(rd_data[i], mem_m[{a, i[1:0]}]);
  endtask
  // One link clock period at the bench's own rate; between calls K rests low.
  task automatic kcyc(input logic rs, input logic ws);
    link2.read_port_select_n = rs;
    link2.write_port_select_n = ws;
    link2.k = 1'b0;
    #80 link2.k = 1'b1;
    link2.k_n = 1'b0;
    #160 link2.k = 1'b0;
    link2.k_n = 1'b1;
    #80;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Cuts a hang short at 2500 cycles, well beyond the 450 or so that the tests need.
  initial begin
    #100000 n_fail++;
    finish_test();
  end
  initial begin
    {rst_n, cmd_valid, cmd_write, cmd_addr, cmd_wdata, cmd_mask} = '0;
    {n_fail, compares} = '0;
    foreach (mem_m[i]) mem_m[i] = '0;
    {link2.k, link2.k_n, link2.read_port_select_n, link2.write_port_select_n} = 4'hf;
    {link2.addr, link2.d, link2.byte_lane_mask_n} = '1;
    repeat (3) @(negedge clk_sys);
    cmp_val({35'h0, link.q_oe}, 36'h0);
    cmp_val({32'h0, link.k, link.k_n, link.read_port_select_n, link.write_port_select_n},
            36'hf);
    rst_n = 1'b1;
    wr_burst(4'h3, {36'h0fedcba98, 36'h123456789, 36'h0a5a5a5a5, 36'h0c3c3c3c3}, '0);
    rd_burst(4'h3);
    wr_burst(4'h3, '0, {4'hf, 4'h7, 4'ha, 4'h0});
    rd_burst(4'h3);
    for (int l = 0; l < 4; l++) begin
      wr_burst(4'h5, {4{36'h555555555}}, {4{4'hf ^ (4'h1 << l)}});
      rd_burst(4'h5);
    end
    $display("Burst and lane mask tests done");
    wr_burst(4'h9, {36'h111111111, 36'h222222222, 36'h333333333, 36'h044444444}, '0);
    rd_burst(4'h9);
    $display("Read after write test done");
    kcyc(1'b0, 1'b1);
    kcyc(1'b0, 1'b1);
    kcyc(1'b1, 1'b1);
    cmp_val(sbp_pkg::word_type'(rd_cnt), 36'h1);
    for (int i = 0; i < 3; i++) begin
      kcyc(1'b0, 1'b0);
      cmp_val(sbp_pkg::word_type'(rd_cnt * 16 + wr_cnt),
              sbp_pkg::word_type'((2 + i / 2) * 16 + (i + 1) / 2));
    end
    $display("Select spacing and arbitration test done");
    finish_test();
  end
endmodule
